// ==== design/serial_port_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH

// Register offsets on the plain register port
`define SP_ADDR_CTRL 3'h0
`define SP_ADDR_BUFFER 3'h1
`define SP_ADDR_POWER 3'h2
`define SP_ADDR_BAUD_CTRL 3'h3
`define SP_ADDR_RELOAD 3'h4
`define SP_ADDR_STATUS 3'h5

// serial_control_reg fields
`define SP_CTRL_MODE_HI 7
`define SP_CTRL_MODE_LO 6
`define SP_CTRL_RX_EN 4
`define SP_CTRL_TX_NINTH 3
`define SP_CTRL_RX_NINTH 2
`define SP_CTRL_TX_DONE 1
`define SP_CTRL_RX_DONE 0

// power_control_reg fields
`define SP_PWR_BAUD_DOUBLE 7
`define SP_PWR_FRAME_CHECK 6

// baud_control_reg fields
`define SP_BAUD_RUN 4
`define SP_BAUD_INTERNAL 2
`define SP_BAUD_PRESCALE_BYPASS 1
`define SP_BAUD_M0_SOURCE 0

// Status register fields
`define SP_STAT_FRAME_ERR 0

// Reset values
`define SP_CTRL_RST 8'h00
`define SP_POWER_RST 8'h00
`define SP_BAUD_CTRL_RST 8'h00
`define SP_RELOAD_RST 8'h00
`define SP_BUFFER_RST 8'h00

// Timing counts in clock cycles, oversample ticks or bits
`define SP_PRESCALE_LAST 3'h5
`define SP_M0_FIXED_HALF_LAST 3'h2
`define SP_M0_VAR_HALF_LAST 3'h7
`define SP_OVERSAMPLE_LAST 4'hF
`define SP_MID_SAMPLE 4'h7
`define SP_BITS_8BIT_LAST 4'h9
`define SP_BITS_9BIT_LAST 4'hA
`define SP_M0_BITS_LAST 4'h7

`endif

// ==== design/serial_port_pkg.sv ====
// Types shared by the serial port design
package serial_port_pkg;

  // Operating mode from the two mode select bits
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'h0,
    MODE_UART8 = 2'h1,
    MODE_UART9_FIXED = 2'h2,
    MODE_UART9_VAR = 2'h3
  } mode_t;

  // Transmit and shift-register sequencer
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_SHIFT,
    TX_ASYNC
  } tx_state_t;

  // Asynchronous receiver
  typedef enum logic [0:0] {
    RX_IDLE,
    RX_BUSY
  } rx_state_t;

endpackage

// ==== design/serial_port_four_mode.sv ====
// Four-mode serial port: synchronous shift mode and three asynchronous UART modes
// Behaviour
// - Mode bits pick shift, 8-bit or 9-bit UART
// - Timer 1 source only in modes 1, 3
// - Timer 1 overflows give bit timing
// - baud_double doubles either source's rate
// - Internal 8-bit reload generator, optional divide-by-6
// - Internal generator runs only with baud_gen_run
// - Mode 0 half-duplex, eight clocks, LSB first
// - Buffer write in mode 0 starts transmission
// - Mode 0: D0 first, end high, set done
// - Control write with receive_enable starts mode 0 receive
// - Mode 0 receive: eight samples, then done flag
// - Mode 0 rate fixed or internal, by source bit
// - Mode 1: ten-bit full-duplex frames
// - Mode 1 stores stop bit as ninth
// - Modes 2, 3: eleven-bit frames, LSB first
// - Modes 2, 3 send and store ninth bit
// - Async receive starts on rx falling edge
// - Mode 2 rate clock/32, or /16 doubled
// - Missing stop bit sets sticky frame error
`timescale 1ns/10ps
`include "serial_port_regs.svh"

module serial_port_four_mode #(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Timer 1 overflow pulse, same clock
  input wire logic timer1_overflow,
  // Serial pins; rx_line is two-way in mode 0
  output logic tx_line,
  input wire logic rx_line_in,
  output logic rx_line_out,
  output logic rx_line_oe
);

  // Software-visible state
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] power_ff, nxt_power;
  logic [7:0] baud_ctrl_ff, nxt_baud_ctrl;
  logic [7:0] reload_ff, nxt_reload;
  logic [DATA_W-1:0] rx_buf_ff, nxt_rx_buf;
  logic frame_err_ff, nxt_frame_err;
  logic [7:0] rdata_ff, nxt_rdata;
  // Baud generation state
  logic [2:0] pre_ff, nxt_pre;
  logic [7:0] gen_ff, nxt_gen;
  logic half_ff, nxt_half;
  logic [2:0] m0div_ff, nxt_m0div;
  // Transmit / shift sequencer
  serial_port_pkg::tx_state_t tx_state_ff, nxt_tx_state;
  logic [10:0] tx_sh_ff, nxt_tx_sh;
  logic [3:0] tx_cnt_ff, nxt_tx_cnt;
  logic [3:0] tx_sub_ff, nxt_tx_sub;
  logic m0_phase_ff, nxt_m0_phase;
  logic m0_rx_ff, nxt_m0_rx;
  logic tx_line_ff, nxt_tx_line;
  logic rx_out_ff, nxt_rx_out;
  logic rx_oe_ff, nxt_rx_oe;
  // Asynchronous receiver
  serial_port_pkg::rx_state_t rx_state_ff, nxt_rx_state;
  logic [10:0] rx_sh_ff, nxt_rx_sh;
  logic [3:0] rx_cnt_ff, nxt_rx_cnt;
  logic [3:0] rx_sub_ff, nxt_rx_sub;
  // Pin synchroniser
  logic rx_meta_ff, rx_s2_ff, rx_s3_ff, rx_level_ff;

  // Decoded controls
  serial_port_pkg::mode_t mode;
  logic baud_double, frame_check, gen_run, prescale_bypass, m0_src_var, use_internal;
  logic rx_enable;
  logic gen_ovf, src_tick, os_tick, m0_half_tick, rx_stable, rx_fall;
  logic wr_ctrl, wr_buf;

  assign mode = serial_port_pkg::mode_t'({ctrl_ff[`SP_CTRL_MODE_HI],
                                          ctrl_ff[`SP_CTRL_MODE_LO]});
  assign baud_double = power_ff[`SP_PWR_BAUD_DOUBLE];
  assign frame_check = power_ff[`SP_PWR_FRAME_CHECK];
  assign gen_run = baud_ctrl_ff[`SP_BAUD_RUN];
  assign prescale_bypass = baud_ctrl_ff[`SP_BAUD_PRESCALE_BYPASS];
  assign m0_src_var = baud_ctrl_ff[`SP_BAUD_M0_SOURCE];
  assign use_internal = baud_ctrl_ff[`SP_BAUD_INTERNAL];
  assign rx_enable = ctrl_ff[`SP_CTRL_RX_EN];
  assign wr_ctrl = reg_wr && (reg_addr == `SP_ADDR_CTRL);
  assign wr_buf = reg_wr && (reg_addr == `SP_ADDR_BUFFER);

  // A change on the pin counts only once the second and third stages agree
  assign rx_stable = (rx_s2_ff == rx_s3_ff);
  assign rx_fall = rx_stable && rx_level_ff && !rx_s3_ff;

  // Baud generation: prescaler, reload timer, source select and doubling
  always_comb begin
    logic pre_tick;
    pre_tick = 1'b0;
    nxt_pre = pre_ff;
    nxt_gen = gen_ff;
    gen_ovf = 1'b0;
    if (gen_run) begin
      pre_tick = prescale_bypass || (pre_ff == `SP_PRESCALE_LAST);
      nxt_pre = (pre_ff == `SP_PRESCALE_LAST) ? 3'h0 : pre_ff + 3'h1;
      if (pre_tick) begin
        if (gen_ff == 8'hFF) begin
          nxt_gen = reload_ff;
          gen_ovf = 1'b1;
        end else begin
          nxt_gen = gen_ff + 8'h01;
        end
      end
    end
    // Timer 1 may only clock the variable UART modes
    case (mode)
      serial_port_pkg::MODE_UART8, serial_port_pkg::MODE_UART9_VAR: begin
        src_tick = use_internal ? gen_ovf : timer1_overflow;
      end
      serial_port_pkg::MODE_UART9_FIXED: begin
        src_tick = 1'b1;
      end
      default: begin
        src_tick = gen_ovf;
      end
    endcase
    // Sixteen oversample ticks per bit; without doubling every second source tick counts
    nxt_half = src_tick ? !half_ff : half_ff;
    os_tick = src_tick && (baud_double || half_ff);
    // Mode 0 half-bit ticks: fixed clock/3 or eight oversample ticks
    m0_half_tick = 1'b0;
    nxt_m0div = m0div_ff;
    if (tx_state_ff != serial_port_pkg::TX_SHIFT) begin
      nxt_m0div = 3'h0;
    end else if (!m0_src_var) begin
      m0_half_tick = (m0div_ff == `SP_M0_FIXED_HALF_LAST);
      nxt_m0div = m0_half_tick ? 3'h0 : m0div_ff + 3'h1;
    end else if (os_tick) begin
      m0_half_tick = (m0div_ff == `SP_M0_VAR_HALF_LAST);
      nxt_m0div = m0_half_tick ? 3'h0 : m0div_ff + 3'h1;
    end
  end

  // Baud generation registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_ff <= 3'h0;
      gen_ff <= 8'h00;
      half_ff <= 1'b0;
      m0div_ff <= 3'h0;
    end else begin
      pre_ff <= nxt_pre;
      gen_ff <= nxt_gen;
      half_ff <= nxt_half;
      m0div_ff <= nxt_m0div;
    end
  end

  // Registers, sequencers and receiver; hardware sets win over software clears
  always_comb begin
    logic set_tx_done, set_rx_done, set_frame_err, rx_ninth_val, async_last;
    logic [3:0] tx_last;
    set_tx_done = 1'b0;
    set_rx_done = 1'b0;
    set_frame_err = 1'b0;
    rx_ninth_val = ctrl_ff[`SP_CTRL_RX_NINTH];
    async_last = 1'b0;
    tx_last = (mode == serial_port_pkg::MODE_UART8) ? `SP_BITS_8BIT_LAST : `SP_BITS_9BIT_LAST;
    nxt_ctrl = wr_ctrl ? reg_wdata : ctrl_ff;
    nxt_power = (reg_wr && reg_addr == `SP_ADDR_POWER) ? reg_wdata : power_ff;
    nxt_baud_ctrl = (reg_wr && reg_addr == `SP_ADDR_BAUD_CTRL) ? reg_wdata : baud_ctrl_ff;
    nxt_reload = (reg_wr && reg_addr == `SP_ADDR_RELOAD) ? reg_wdata : reload_ff;
    nxt_frame_err = frame_err_ff;
    if (reg_wr && reg_addr == `SP_ADDR_STATUS) begin
      nxt_frame_err = reg_wdata[`SP_STAT_FRAME_ERR];
    end
    nxt_rx_buf = rx_buf_ff;
    nxt_tx_state = tx_state_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_sub = tx_sub_ff;
    nxt_m0_phase = m0_phase_ff;
    nxt_m0_rx = m0_rx_ff;
    nxt_tx_line = tx_line_ff;
    nxt_rx_out = rx_out_ff;
    nxt_rx_oe = rx_oe_ff;
    nxt_rx_state = rx_state_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_sub = rx_sub_ff;

    // Transmit and mode 0 shift sequencer
    case (tx_state_ff)
      serial_port_pkg::TX_IDLE: begin
        nxt_tx_line = 1'b1;
        nxt_rx_out = 1'b1;
        nxt_rx_oe = 1'b0;
        if (wr_buf && mode == serial_port_pkg::MODE_SHIFT) begin
          nxt_tx_state = serial_port_pkg::TX_SHIFT;
          nxt_tx_sh = {3'h7, reg_wdata};
          nxt_tx_cnt = 4'h0;
          nxt_m0_phase = 1'b0;
          nxt_m0_rx = 1'b0;
          nxt_rx_out = reg_wdata[0];
          nxt_rx_oe = 1'b1;
        end else if (wr_ctrl && reg_wdata[`SP_CTRL_MODE_HI:`SP_CTRL_MODE_LO] == 2'h0
                     && reg_wdata[`SP_CTRL_RX_EN] && !reg_wdata[`SP_CTRL_RX_DONE]) begin
          nxt_tx_state = serial_port_pkg::TX_SHIFT;
          nxt_tx_cnt = 4'h0;
          nxt_m0_phase = 1'b0;
          nxt_m0_rx = 1'b1;
        end else if (wr_buf) begin
          nxt_tx_state = serial_port_pkg::TX_ASYNC;
          // Ninth slot carries the stop level in mode 1, the programmed bit otherwise
          nxt_tx_sh = {1'b1, (mode == serial_port_pkg::MODE_UART8) ? 1'b1
                       : ctrl_ff[`SP_CTRL_TX_NINTH], reg_wdata, 1'b0};
          nxt_tx_cnt = 4'h0;
          nxt_tx_sub = 4'h0;
        end
      end
      serial_port_pkg::TX_SHIFT: begin
        // Each bit: clock high half, then low half; pin data changes at bit start
        if (m0_half_tick) begin
          if (!m0_phase_ff) begin
            nxt_m0_phase = 1'b1;
            nxt_tx_line = 1'b0;
          end else begin
            nxt_m0_phase = 1'b0;
            nxt_tx_line = 1'b1;
            nxt_tx_sh = {2'h3, rx_level_ff, tx_sh_ff[8:1]};
            nxt_tx_cnt = tx_cnt_ff + 4'h1;
            nxt_rx_out = m0_rx_ff ? 1'b1 : tx_sh_ff[1];
            if (tx_cnt_ff == `SP_M0_BITS_LAST) begin
              nxt_tx_state = serial_port_pkg::TX_IDLE;
              nxt_rx_out = 1'b1;
              if (m0_rx_ff) begin
                set_rx_done = 1'b1;
                nxt_rx_buf = {rx_level_ff, tx_sh_ff[8:2]};
              end else begin
                set_tx_done = 1'b1;
              end
            end
          end
        end
      end
      serial_port_pkg::TX_ASYNC: begin
        // Start bit opens on an oversample tick, else it could come up one clock short
        if (os_tick && tx_cnt_ff == 4'h0 && tx_line_ff) begin
          nxt_tx_line = 1'b0;
        end else if (os_tick) begin
          nxt_tx_sub = tx_sub_ff + 4'h1;
          if (tx_sub_ff == `SP_OVERSAMPLE_LAST) begin
            nxt_tx_sh = {1'b1, tx_sh_ff[10:1]};
            nxt_tx_line = tx_sh_ff[1];
            nxt_tx_cnt = tx_cnt_ff + 4'h1;
            if (tx_cnt_ff == tx_last) begin
              nxt_tx_state = serial_port_pkg::TX_IDLE;
              nxt_tx_line = 1'b1;
              set_tx_done = 1'b1;
            end
          end
        end
      end
      default: begin
        nxt_tx_state = serial_port_pkg::TX_IDLE;
      end
    endcase

    // Asynchronous receiver, sampling at mid-bit of sixteen ticks
    case (rx_state_ff)
      serial_port_pkg::RX_IDLE: begin
        if (rx_fall && rx_enable && mode != serial_port_pkg::MODE_SHIFT) begin
          nxt_rx_state = serial_port_pkg::RX_BUSY;
          nxt_rx_sub = 4'h0;
          nxt_rx_cnt = 4'h0;
        end
      end
      serial_port_pkg::RX_BUSY: begin
        if (mode == serial_port_pkg::MODE_SHIFT) begin
          nxt_rx_state = serial_port_pkg::RX_IDLE;
        end else if (os_tick) begin
          nxt_rx_sub = rx_sub_ff + 4'h1;
          if (rx_sub_ff == `SP_MID_SAMPLE) begin
            nxt_rx_sh = {rx_level_ff, rx_sh_ff[10:1]};
            nxt_rx_cnt = rx_cnt_ff + 4'h1;
            if (rx_cnt_ff == 4'h0 && rx_level_ff) begin
              nxt_rx_state = serial_port_pkg::RX_IDLE; // False start, back to hunting
            end else if (rx_cnt_ff == tx_last) begin
              async_last = 1'b1;
              nxt_rx_state = serial_port_pkg::RX_IDLE;
            end
          end
        end
      end
      default: begin
        nxt_rx_state = serial_port_pkg::RX_IDLE;
      end
    endcase
    if (async_last) begin
      set_rx_done = 1'b1;
      if (mode == serial_port_pkg::MODE_UART8) begin
        nxt_rx_buf = rx_sh_ff[10:3];
        rx_ninth_val = rx_level_ff;
      end else begin
        nxt_rx_buf = rx_sh_ff[9:2];
        rx_ninth_val = rx_sh_ff[10];
      end
      set_frame_err = frame_check && !rx_level_ff;
    end

    // Hardware events override the software write in the same cycle
    if (async_last) begin
      nxt_ctrl[`SP_CTRL_RX_NINTH] = rx_ninth_val;
    end
    if (set_tx_done) begin
      nxt_ctrl[`SP_CTRL_TX_DONE] = 1'b1;
    end
    if (set_rx_done) begin
      nxt_ctrl[`SP_CTRL_RX_DONE] = 1'b1;
    end
    if (set_frame_err) begin
      nxt_frame_err = 1'b1;
    end

    // Read data stands in the cycle after the read strobe
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `SP_ADDR_CTRL: nxt_rdata = ctrl_ff;
        `SP_ADDR_BUFFER: nxt_rdata = rx_buf_ff;
        `SP_ADDR_POWER: nxt_rdata = power_ff;
        `SP_ADDR_BAUD_CTRL: nxt_rdata = baud_ctrl_ff;
        `SP_ADDR_RELOAD: nxt_rdata = reload_ff;
        `SP_ADDR_STATUS: nxt_rdata = {7'h00, frame_err_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // Main state registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= `SP_CTRL_RST;
      power_ff <= `SP_POWER_RST;
      baud_ctrl_ff <= `SP_BAUD_CTRL_RST;
      reload_ff <= `SP_RELOAD_RST;
      rx_buf_ff <= `SP_BUFFER_RST;
      frame_err_ff <= 1'b0;
      rdata_ff <= 8'h00;
      tx_state_ff <= serial_port_pkg::TX_IDLE;
      tx_sh_ff <= 11'h7FF;
      tx_cnt_ff <= 4'h0;
      tx_sub_ff <= 4'h0;
      m0_phase_ff <= 1'b0;
      m0_rx_ff <= 1'b0;
      tx_line_ff <= 1'b1;
      rx_out_ff <= 1'b1;
      rx_oe_ff <= 1'b0;
      rx_state_ff <= serial_port_pkg::RX_IDLE;
      rx_sh_ff <= 11'h000;
      rx_cnt_ff <= 4'h0;
      rx_sub_ff <= 4'h0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      power_ff <= nxt_power;
      baud_ctrl_ff <= nxt_baud_ctrl;
      reload_ff <= nxt_reload;
      rx_buf_ff <= nxt_rx_buf;
      frame_err_ff <= nxt_frame_err;
      rdata_ff <= nxt_rdata;
      tx_state_ff <= nxt_tx_state;
      tx_sh_ff <= nxt_tx_sh;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_sub_ff <= nxt_tx_sub;
      m0_phase_ff <= nxt_m0_phase;
      m0_rx_ff <= nxt_m0_rx;
      tx_line_ff <= nxt_tx_line;
      rx_out_ff <= nxt_rx_out;
      rx_oe_ff <= nxt_rx_oe;
      rx_state_ff <= nxt_rx_state;
      rx_sh_ff <= nxt_rx_sh;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_sub_ff <= nxt_rx_sub;
    end
  end

  // Three-stage pin synchroniser; the filtered level moves only when stages agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_meta_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      rx_s3_ff <= 1'b1;
      rx_level_ff <= 1'b1;
    end else begin
      rx_meta_ff <= rx_line_in;
      rx_s2_ff <= rx_meta_ff;
      rx_s3_ff <= rx_s2_ff;
      rx_level_ff <= rx_stable ? rx_s3_ff : rx_level_ff;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_ff;
  assign tx_line = tx_line_ff;
  assign rx_line_out = rx_out_ff;
  assign rx_line_oe = rx_oe_ff;

endmodule // serial_port_four_mode

// ==== dv/serial_port_checker.sv ====
// Assertion checker for the serial port pins and register port
`timescale 1ns/10ps
`include "serial_port_regs.svh"

module serial_port_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Timer and serial pins
  input wire logic timer1_overflow,
  input wire logic tx_line,
  input wire logic rx_line_in,
  input wire logic rx_line_out,
  input wire logic rx_line_oe
);
  logic [1:0] mode_ff, nxt_mode;
  logic dbl_ff, nxt_dbl, var_ff, nxt_var;
  logic [11:0] lo_ff, nxt_lo, oe_ff, nxt_oe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Shadow software's mode and rate bits; run lengths give bit timing
  always_comb begin
    nxt_mode = mode_ff;
    nxt_dbl = dbl_ff;
    nxt_var = var_ff;
    if (reg_wr && reg_addr == `SP_ADDR_CTRL) nxt_mode = reg_wdata[7:6];
    if (reg_wr && reg_addr == `SP_ADDR_POWER) nxt_dbl = reg_wdata[7];
    if (reg_wr && reg_addr == `SP_ADDR_BAUD_CTRL) nxt_var = reg_wdata[0];
    nxt_lo = tx_line ? 12'h000 : lo_ff + 12'h001;
    nxt_oe = rx_line_oe ? oe_ff + 12'h001 : 12'h000;
  end

  // Helper registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_ff <= 2'h0;
      dbl_ff <= 1'b0;
      var_ff <= 1'b0;
      lo_ff <= 12'h000;
      oe_ff <= 12'h000;
    end else begin
      mode_ff <= nxt_mode;
      dbl_ff <= nxt_dbl;
      var_ff <= nxt_var;
      lo_ff <= nxt_lo;
      oe_ff <= nxt_oe;
    end
  end

  // One shift-clock half period at the fixed rate
  sequence s_clk_high;
    tx_line [*3];
  endsequence
  sequence s_clk_low;
    !tx_line [*3];
  endsequence

  rdata_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  m0_only_mode0_a: assert property (rx_line_oe |-> mode_ff == 2'h0)
    else $error("data pin driven outside shift mode");
  m0_write_start_a: assert property ($rose(rx_line_oe) |->
    $past(reg_wr) && $past(reg_addr) == `SP_ADDR_BUFFER)
    else $error("shift-out began without a buffer write");
  m0_clock_shape_a: assert property ($rose(rx_line_oe) && !var_ff |->
    s_clk_high ##1 s_clk_low ##1 tx_line)
    else $error("first shift clock not high then low");
  m0_bit_steady_a: assert property (rx_line_oe && $past(rx_line_oe) &&
    $changed(rx_line_out) |-> $rose(tx_line))
    else $error("shift data changed mid clock");
  m0_eight_bits_a: assert property ($fell(rx_line_oe) && !var_ff |->
    oe_ff == 12'h031) // Eight six-cycle bits and one closing high cycle
    else $error("shift-out not eight fixed-rate bits");
  m0_end_high_a: assert property ($fell(rx_line_oe) |-> tx_line && rx_line_out)
    else $error("shift-out did not end high");
  m2_bit_time_a: assert property ($rose(tx_line) && mode_ff == 2'h2 |->
    lo_ff[3:0] == 4'h0 && (dbl_ff || !lo_ff[4]))
    else $error("fixed-rate bit length wrong");
endmodule // serial_port_checker

bind serial_port_four_mode serial_port_checker serial_port_checker_inst (
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .timer1_overflow(timer1_overflow), .tx_line(tx_line), .rx_line_in(rx_line_in),
  .rx_line_out(rx_line_out), .rx_line_oe(rx_line_oe)
);

// ==== dv/serial_far_end.sv ====
// Far-end model: external shift register and remote asynchronous node
`timescale 1ns/10ps

module serial_far_end (
  // Clock
  input wire logic clk,
  // Device pins
  input wire logic tx_line,
  input wire logic rx_line_out,
  input wire logic rx_line_oe,
  output logic rx_drive
);
  logic m0_act = 1'b0;
  logic line = 1'b1;
  logic [7:0] sh = 8'hFF;
  logic [7:0] cap = 8'h00;
  int n_cap = 0;

  // Idle line rests high; in shift mode the register's low bit is on the pin
  assign rx_drive = m0_act ? sh[0] : line;

  // Advance on each rising shift clock; ones fill in so a spent register reads high
  always @(posedge tx_line) if (m0_act) sh <= {1'b1, sh[7:1]};

  // Capture mid-bit, on the falling clock, while the device drives data
  always @(negedge tx_line) begin
    if (rx_line_oe) begin
      cap <= {rx_line_out, cap[7:1]};
      n_cap <= n_cap + 1;
    end
  end

  task automatic load(input logic [7:0] d);
    sh <= d;
    m0_act <= 1'b1;
  endtask

  // Start, LSB-first data, optional ninth, stop; bc clocks per bit
  task automatic send_frame(input logic [8:0] d, input int nb, input logic stop, input int bc);
    m0_act <= 1'b0;
    @(posedge clk);
    line <= 1'b0;
    repeat (bc) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      line <= d[i];
      repeat (bc) @(posedge clk);
    end
    line <= stop;
    repeat (bc) @(posedge clk);
    line <= 1'b1;
  endtask

  // Wait for a start bit, then sample every bit at its middle
  task automatic get_frame(input int nb, input int bc, output logic [8:0] d,
                           output logic stp, output bit ok);
    ok = 1'b0;
    d = 9'h000;
    for (int i = 0; i < 4000 && !ok; i++) begin
      @(posedge clk);
      ok = (tx_line === 1'b0);
    end
    repeat (bc / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      repeat (bc) @(posedge clk);
      d[i] = tx_line;
    end
    repeat (bc) @(posedge clk);
    stp = tx_line;
  endtask
endmodule // serial_far_end

// ==== dv/serial_port_four_mode_bench.sv ====
// Self-checking bench for the four-mode serial port
`timescale 1ns/10ps
`include "serial_port_regs.svh"

module serial_port_four_mode_bench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic t1_en = 1'b0;
  logic timer1_overflow = 1'b0;
  logic tx_line, rx_line_out, rx_line_oe, rx_drive;
  logic [7:0] v;
  logic [8:0] fr;
  logic stp;
  bit ok;
  int n_mismatch = 0;
  int n_compared = 0;
  // Pin level: the device wins while it drives, else the far end
  wire rx_pin = rx_line_oe ? rx_line_out : rx_drive;

  always #12.5 clk = ~clk;
  // Overflow pulse every second clock, standing in for Timer 1
  always @(posedge clk) timer1_overflow <= t1_en & ~timer1_overflow;

  serial_port_four_mode serial_port_four_mode_inst (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer1_overflow(timer1_overflow), .tx_line(tx_line), .rx_line_in(rx_pin),
    .rx_line_out(rx_line_out), .rx_line_oe(rx_line_oe));
  serial_far_end serial_far_end_inst (
    .clk(clk), .tx_line(tx_line), .rx_line_out(rx_line_out), .rx_line_oe(rx_line_oe),
    .rx_drive(rx_drive));

  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  // Poll a flag with a bounded count; running out ends the run
  task automatic wait_bit(input logic [2:0] a, input int b);
    logic [7:0] f;
    f = 8'h00;
    for (int i = 0; i < 2000 && f[b] !== 1'b1; i++) rd(a, f);
    if (f[b] !== 1'b1) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, f, 8'h01 << b);
      n_mismatch++;
      end_sim();
    end
  endtask

  task automatic t_reset;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], v);
      chk({1'b0, v}, 9'h000);
    end
    wr(3'h7, 8'hFF);
    rd(3'h7, v);
    chk({1'b0, v}, 9'h000);
    $display("test reset done");
  endtask

  task automatic t_m0_tx;
    wr(`SP_ADDR_CTRL, 8'h00);
    wr(`SP_ADDR_BUFFER, 8'hA5);
    wait_bit(`SP_ADDR_CTRL, `SP_CTRL_TX_DONE);
    chk({1'b0, serial_far_end_inst.cap}, 9'h0A5);
    chk(serial_far_end_inst.n_cap[8:0], 9'h008);
    chk({7'h00, rx_line_oe, rx_line_out}, 9'h001);
    $display("test m0_tx done");
  endtask

  task automatic t_m0_rx;
    wr(`SP_ADDR_BAUD_CTRL, 8'h13);
    wr(`SP_ADDR_RELOAD, 8'hFF);
    serial_far_end_inst.load(8'h3C);
    wr(`SP_ADDR_CTRL, 8'h10);
    wait_bit(`SP_ADDR_CTRL, `SP_CTRL_RX_DONE);
    rd(`SP_ADDR_BUFFER, v);
    chk({1'b0, v}, 9'h03C);
    $display("test m0_rx done");
  endtask

  task automatic t_m2_tx;
    wr(`SP_ADDR_CTRL, 8'h88);
    wr(`SP_ADDR_BUFFER, 8'h5A);
    serial_far_end_inst.get_frame(9, 32, fr, stp, ok);
    chk({8'h00, ok}, 9'h001);
    chk(fr, 9'h15A);
    chk({8'h00, stp}, 9'h001);
    wait_bit(`SP_ADDR_CTRL, `SP_CTRL_TX_DONE);
    $display("test m2_tx done");
  endtask

  task automatic t_m3_rx;
    wr(`SP_ADDR_BAUD_CTRL, 8'h14);
    wr(`SP_ADDR_RELOAD, 8'hFF);
    wr(`SP_ADDR_POWER, 8'h80);
    wr(`SP_ADDR_CTRL, 8'hD0);
    serial_far_end_inst.send_frame(9'h1C3, 9, 1'b1, 96);
    wait_bit(`SP_ADDR_CTRL, `SP_CTRL_RX_DONE);
    rd(`SP_ADDR_BUFFER, v);
    chk({1'b0, v}, 9'h0C3);
    rd(`SP_ADDR_CTRL, v);
    chk({8'h00, v[`SP_CTRL_RX_NINTH]}, 9'h001);
    $display("test m3_rx done");
  endtask

  task automatic t_m1_fe;
    wr(`SP_ADDR_BAUD_CTRL, 8'h00);
    t1_en <= 1'b1;
    wr(`SP_ADDR_POWER, 8'hC0);
    wr(`SP_ADDR_CTRL, 8'h50);
    serial_far_end_inst.send_frame(9'h081, 8, 1'b0, 32);
    wait_bit(`SP_ADDR_CTRL, `SP_CTRL_RX_DONE);
    rd(`SP_ADDR_STATUS, v);
    chk({8'h00, v[`SP_STAT_FRAME_ERR]}, 9'h001);
    rd(`SP_ADDR_CTRL, v);
    chk({8'h00, v[`SP_CTRL_RX_NINTH]}, 9'h000);
    wr(`SP_ADDR_CTRL, 8'h50);
    serial_far_end_inst.send_frame(9'h042, 8, 1'b1, 32);
    wait_bit(`SP_ADDR_CTRL, `SP_CTRL_RX_DONE);
    rd(`SP_ADDR_BUFFER, v);
    chk({1'b0, v}, 9'h042);
    rd(`SP_ADDR_STATUS, v);
    chk({8'h00, v[`SP_STAT_FRAME_ERR]}, 9'h001);
    rd(`SP_ADDR_CTRL, v);
    chk({8'h00, v[`SP_CTRL_RX_NINTH]}, 9'h001);
    $display("test m1_fe done");
  endtask

  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_m0_tx();
    t_m0_rx();
    t_m2_tx();
    t_m3_rx();
    t_m1_fe();
    end_sim();
  end
endmodule // serial_port_four_mode_bench
